//--- hw/frps_pkg.sv
package frps_pkg;

  // ****************************************
  // widths and depth
  // ****************************************
  localparam int FRPS_WORD_W = 40;
  localparam int FRPS_HALF_W = 20;
  localparam int FRPS_QTR_W = 10;
  localparam int FRPS_DEPTH_DEF = 16384;
  localparam int FRPS_OFS_W = 18;

  // ****************************************
  // port width codes and last sub-word numbers
  // ****************************************
  typedef enum logic [1:0] {
    FRPS_W40 = 2'b00,
    FRPS_W20 = 2'b01,
    FRPS_W10 = 2'b10
  } frps_width_t;

  localparam logic [1:0] FRPS_SUB_LAST_W40 = 2'h0;
  localparam logic [1:0] FRPS_SUB_LAST_W20 = 2'h1;
  localparam logic [1:0] FRPS_SUB_LAST_W10 = 2'h3;

  // ****************************************
  // default almost-empty / almost-full offsets
  // ****************************************
  localparam logic [FRPS_OFS_W-1:0] FRPS_OFS_PRESET0 = 18'h00007;
  localparam logic [FRPS_OFS_W-1:0] FRPS_OFS_PRESET1 = 18'h0001F;
  localparam logic [FRPS_OFS_W-1:0] FRPS_OFS_PRESET2 = 18'h0003F;
  localparam logic [FRPS_OFS_W-1:0] FRPS_OFS_PRESET3 = 18'h0007F;

  // ****************************************
  // layout of the synchronised pin vector
  // ****************************************
  localparam int FRPS_PIN_WCLK = 40;
  localparam int FRPS_PIN_RCLK = 41;
  localparam int FRPS_PIN_MRST = 42;
  localparam int FRPS_PIN_PRST = 43;
  localparam int FRPS_PIN_WEN = 44;
  localparam int FRPS_PIN_WSEL = 45;
  localparam int FRPS_PIN_REN = 46;
  localparam int FRPS_PIN_RSEL = 47;
  localparam int FRPS_PIN_ODRV = 48;
  localparam int FRPS_PIN_BM = 49;
  localparam int FRPS_PIN_IW = 50;
  localparam int FRPS_PIN_OW = 51;
  localparam int FRPS_PIN_FS0 = 52;
  localparam int FRPS_PIN_FS1 = 53;
  localparam int FRPS_PIN_FIRST_WORD_FALLTHROUGH = 54;
  localparam int FRPS_PIN_RTM = 55;
  localparam int FRPS_PIN_MARK = 56;
  localparam int FRPS_PIN_W = 57;

endpackage

//--- hw/frps_sync_if.sv
`timescale 1ns/1ns
interface frps_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] lvl;
  logic [W-1:0] rise;
  modport src (input raw, output lvl, output rise);
  modport dst (output raw, input lvl, input rise);
endinterface

//--- hw/frps_pin_sync.sv
`timescale 1ns/1ns
module frps_pin_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  frps_sync_if.src sync_io
);

  // ****************************************
  // two-flop synchroniser plus edge history
  // ****************************************
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] hist_ff;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
      hist_ff <= '0;
    end else begin
      meta_ff <= sync_io.raw;
      sync_ff <= meta_ff;
      hist_ff <= sync_ff;
    end
  end

  // edge detect looks only at the second and third stage
  assign sync_io.lvl = sync_ff;
  assign sync_io.rise = sync_ff & ~hist_ff;

endmodule

//--- hw/frps_top.sv
`timescale 1ns/1ns
module frps_top import frps_pkg::*; #(
  parameter int DEPTH = FRPS_DEPTH_DEF
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic write_clk_i,
  input wire logic read_clk_i,
  input wire logic master_reset_n_i,
  input wire logic partial_reset_n_i,
  input wire logic write_en_n_i,
  input wire logic write_port_select_n_i,
  input wire logic [FRPS_WORD_W-1:0] write_data_i,
  input wire logic read_en_n_i,
  input wire logic read_port_select_n_i,
  input wire logic output_drive_n_i,
  input wire logic bus_match_enable_i,
  input wire logic input_width_sel_i,
  input wire logic output_width_sel_i,
  input wire logic offset_preset_sel0_i,
  input wire logic offset_preset_sel1_i,
  input wire logic first_word_fallthrough_i,
  input wire logic retransmit_mode_i,
  input wire logic mark_i,
  output logic [FRPS_WORD_W-1:0] read_data_o,
  output logic [FRPS_WORD_W-1:0] read_data_oe_o,
  output logic full_flag_input_ready_o,
  output logic empty_flag_output_ready_o,
  output logic almost_full_flag_n_o,
  output logic almost_empty_flag_n_o,
  output logic echo_read_clock_o,
  output logic echo_read_strobe_n_o
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 2;
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [CW-1:0] ONE_C = CW'(1);

  // ****************************************
  // pin synchronisation
  // ****************************************
  frps_sync_if #(.W(FRPS_PIN_W)) pins ();

  assign pins.raw = {mark_i, retransmit_mode_i, first_word_fallthrough_i,
                     offset_preset_sel1_i, offset_preset_sel0_i, output_width_sel_i,
                     input_width_sel_i, bus_match_enable_i, output_drive_n_i,
                     read_port_select_n_i, read_en_n_i, write_port_select_n_i,
                     write_en_n_i, partial_reset_n_i, master_reset_n_i,
                     read_clk_i, write_clk_i, write_data_i};

  frps_pin_sync #(.W(FRPS_PIN_W)) u_sync (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .sync_io(pins)
  );

  wire wclk_rise = pins.rise[FRPS_PIN_WCLK];
  wire rclk_rise = pins.rise[FRPS_PIN_RCLK];
  wire in_mrst = ~pins.lvl[FRPS_PIN_MRST];
  wire in_rst = in_mrst | ~pins.lvl[FRPS_PIN_PRST];
  wire wen = ~pins.lvl[FRPS_PIN_WEN];
  wire wsel = ~pins.lvl[FRPS_PIN_WSEL];
  wire ren = ~pins.lvl[FRPS_PIN_REN];
  wire rsel = ~pins.lvl[FRPS_PIN_RSEL];
  wire [FRPS_WORD_W-1:0] wdata = pins.lvl[FRPS_WORD_W-1:0];

  // ****************************************
  // configuration caught during master reset
  // ****************************************
  frps_width_t cfg_in_w_ff;
  frps_width_t cfg_out_w_ff;
  logic cfg_first_word_fallthrough_ff;
  logic [FRPS_OFS_W-1:0] cfg_ofs_ff;

  wire bm = pins.lvl[FRPS_PIN_BM];
  wire iw = pins.lvl[FRPS_PIN_IW];
  wire ow = pins.lvl[FRPS_PIN_OW];
  wire frps_width_t nxt_in_w = !bm ? FRPS_W40 : (!iw ? FRPS_W40 : (ow ? FRPS_W10 : FRPS_W20));
  wire frps_width_t nxt_out_w = !bm ? FRPS_W40 : (iw ? FRPS_W40 : (ow ? FRPS_W10 : FRPS_W20));
  wire [1:0] fsel = {pins.lvl[FRPS_PIN_FS1], pins.lvl[FRPS_PIN_FS0]};
  wire [FRPS_OFS_W-1:0] nxt_ofs = (fsel == 2'h0) ? FRPS_OFS_PRESET0 :
                                  (fsel == 2'h1) ? FRPS_OFS_PRESET1 :
                                  (fsel == 2'h2) ? FRPS_OFS_PRESET2 : FRPS_OFS_PRESET3;

  // later changes of these pins are ignored on purpose
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_in_w_ff <= FRPS_W40;
      cfg_out_w_ff <= FRPS_W40;
      cfg_first_word_fallthrough_ff <= 1'b0;
      cfg_ofs_ff <= FRPS_OFS_PRESET0;
    end else if (in_mrst) begin
      cfg_in_w_ff <= nxt_in_w;
      cfg_out_w_ff <= nxt_out_w;
      cfg_first_word_fallthrough_ff <= pins.lvl[FRPS_PIN_FIRST_WORD_FALLTHROUGH];
      cfg_ofs_ff <= nxt_ofs;
    end
  end

  function automatic logic [1:0] frps_sub_last(input frps_width_t w);
    unique case (w)
      FRPS_W40: frps_sub_last = FRPS_SUB_LAST_W40;
      FRPS_W20: frps_sub_last = FRPS_SUB_LAST_W20;
      FRPS_W10: frps_sub_last = FRPS_SUB_LAST_W10;
      default: frps_sub_last = FRPS_SUB_LAST_W40;
    endcase
  endfunction

  // picks sub-word number sub, most significant first, into the low lines
  function automatic logic [FRPS_WORD_W-1:0] frps_slice(input logic [FRPS_WORD_W-1:0] e,
                                                         input logic [1:0] sub,
                                                         input frps_width_t w);
    logic [FRPS_WORD_W-1:0] h;
    logic [FRPS_WORD_W-1:0] q;
    h = e << (FRPS_HALF_W * sub[0]);
    q = e << (FRPS_QTR_W * sub);
    unique case (w)
      FRPS_W40: frps_slice = e;
      FRPS_W20: frps_slice = {{FRPS_HALF_W{1'b0}}, h[FRPS_WORD_W-1 -: FRPS_HALF_W]};
      FRPS_W10: frps_slice = {{(FRPS_WORD_W-FRPS_QTR_W){1'b0}}, q[FRPS_WORD_W-1 -: FRPS_QTR_W]};
      default: frps_slice = e;
    endcase
  endfunction

  // ****************************************
  // storage and pointers
  // ****************************************
  logic [FRPS_WORD_W-1:0] mem [DEPTH];
  logic [PW:0] wptr_ff;
  logic [PW:0] rptr_ff;
  logic [PW:0] mark_ff;
  logic ovalid_ff;

  // differences taken at pointer width so that wrap-around stays right
  wire [PW:0] mem_diff = wptr_ff - rptr_ff;
  wire [PW:0] mark_diff = wptr_ff - mark_ff;
  wire [CW-1:0] mem_cnt = CW'(mem_diff);
  wire [CW-1:0] wr_cnt = pins.lvl[FRPS_PIN_RTM] ? CW'(mark_diff) : mem_cnt;
  wire [CW-1:0] out_reg_cnt = CW'(cfg_first_word_fallthrough_ff & ovalid_ff);
  wire [CW-1:0] tot_wr = wr_cnt + out_reg_cnt;
  wire [CW-1:0] tot_rd = mem_cnt + out_reg_cnt;
  wire mem_empty = (mem_cnt == '0);
  wire full_raw = (wr_cnt == DEPTH_C);

  // ****************************************
  // write side
  // ****************************************
  logic [FRPS_WORD_W-1:0] wacc_ff;
  logic [1:0] wsub_ff;

  wire wr_go = wclk_rise & wen & wsel & ~in_rst & ~full_raw;
  wire wr_last = (wsub_ff == frps_sub_last(cfg_in_w_ff));
  wire [FRPS_WORD_W-1:0] wr_entry =
    (cfg_in_w_ff == FRPS_W20) ? {wacc_ff[FRPS_HALF_W-1:0], wdata[FRPS_HALF_W-1:0]} :
    (cfg_in_w_ff == FRPS_W10) ? {wacc_ff[FRPS_WORD_W-FRPS_QTR_W-1:0], wdata[FRPS_QTR_W-1:0]} :
    wdata;

  always_ff @(posedge clk_sys_i) begin
    if (wr_go && wr_last) begin
      mem[wptr_ff[PW-1:0]] <= wr_entry;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wptr_ff <= '0;
      wsub_ff <= 2'h0;
      wacc_ff <= '0;
    end else if (in_rst) begin
      wptr_ff <= '0;
      wsub_ff <= 2'h0;
    end else if (wr_go) begin
      wacc_ff <= wr_entry;
      wsub_ff <= wr_last ? 2'h0 : wsub_ff + 2'h1;
      wptr_ff <= wr_last ? wptr_ff + 1'b1 : wptr_ff;
    end
  end

  // ****************************************
  // read side
  // ****************************************
  logic [FRPS_WORD_W-1:0] hold_ff;
  logic [FRPS_WORD_W-1:0] read_data_ff;
  logic [1:0] rsub_ff;
  logic [2:0] empty_pipe_ff;

  wire rsub_last = (rsub_ff == frps_sub_last(cfg_out_w_ff));
  wire std_have = ~mem_empty | (rsub_ff != 2'h0);
  wire rd_std = ~cfg_first_word_fallthrough_ff & rclk_rise & ren & rsel & ~in_rst & std_have;
  wire rd_std_pop = rd_std & (rsub_ff == 2'h0);
  wire rd_true = cfg_first_word_fallthrough_ff & rclk_rise & ren & rsel & ~in_rst & ovalid_ff;
  // fall-through into an empty output register needs neither strobe nor select, only not-empty both now and delayed
  wire ft_load = cfg_first_word_fallthrough_ff & rclk_rise & ~in_rst & ~mem_empty & ~empty_pipe_ff[1] &
                 (~ovalid_ff | (rd_true & rsub_last));
  wire ft_drain = rd_true & rsub_last & ~ft_load;
  wire ft_step = rd_true & ~rsub_last;
  wire rd_event = rd_std | rd_true;
  wire [FRPS_WORD_W-1:0] mem_head = mem[rptr_ff[PW-1:0]];
  wire [FRPS_WORD_W-1:0] std_src = (rsub_ff == 2'h0) ? mem_head : hold_ff;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rptr_ff <= '0;
      rsub_ff <= 2'h0;
      ovalid_ff <= 1'b0;
      hold_ff <= '0;
      read_data_ff <= '0;
    end else if (in_rst) begin
      rptr_ff <= '0;
      rsub_ff <= 2'h0;
      ovalid_ff <= 1'b0;
    end else if (rd_std) begin
      hold_ff <= rd_std_pop ? mem_head : hold_ff;
      read_data_ff <= frps_slice(std_src, rsub_ff, cfg_out_w_ff);
      rsub_ff <= rsub_last ? 2'h0 : rsub_ff + 2'h1;
      rptr_ff <= rd_std_pop ? rptr_ff + 1'b1 : rptr_ff;
    end else if (ft_load) begin
      hold_ff <= mem_head;
      read_data_ff <= frps_slice(mem_head, 2'h0, cfg_out_w_ff);
      rsub_ff <= 2'h0;
      ovalid_ff <= 1'b1;
      rptr_ff <= rptr_ff + 1'b1;
    end else if (ft_step) begin
      read_data_ff <= frps_slice(hold_ff, rsub_ff + 2'h1, cfg_out_w_ff);
      rsub_ff <= rsub_ff + 2'h1;
    end else if (ft_drain) begin
      ovalid_ff <= 1'b0;
    end
  end

  // mark follows the read pointer; the reader keeps select low for retransmit
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mark_ff <= '0;
    end else if (in_rst) begin
      mark_ff <= '0;
    end else if (rclk_rise && pins.lvl[FRPS_PIN_MARK]) begin
      mark_ff <= rptr_ff;
    end
  end

  // ****************************************
  // flags
  // ****************************************
  logic [1:0] full_pipe_ff;
  logic af_n_ff;
  logic ae_n_ff;

  wire [CW-1:0] ofs_c = CW'(cfg_ofs_ff);
  wire [CW-1:0] af_lim = DEPTH_C + out_reg_cnt - ofs_c;
  wire [CW-1:0] ae_lim = ofs_c + (cfg_first_word_fallthrough_ff ? ONE_C : '0);
  wire std_empty_raw = mem_empty & (rsub_ff == 2'h0);

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      full_pipe_ff <= 2'b00;
      af_n_ff <= 1'b1;
    end else if (in_rst) begin
      full_pipe_ff <= 2'b00;
      af_n_ff <= 1'b1;
    end else if (wclk_rise) begin
      full_pipe_ff <= {full_pipe_ff[0], full_raw};
      af_n_ff <= ~(tot_wr >= af_lim);
    end
  end

  // select does not enter any of these terms
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      empty_pipe_ff <= 3'b111;
      ae_n_ff <= 1'b0;
    end else if (in_rst) begin
      empty_pipe_ff <= 3'b111;
      ae_n_ff <= 1'b0;
    end else if (rclk_rise) begin
      empty_pipe_ff <= {empty_pipe_ff[1:0], std_empty_raw};
      ae_n_ff <= ~(tot_rd <= ae_lim);
    end
  end

  assign full_flag_input_ready_o = cfg_first_word_fallthrough_ff ? full_pipe_ff[1] : ~full_pipe_ff[1];
  assign empty_flag_output_ready_o = cfg_first_word_fallthrough_ff ? ~ovalid_ff : ~empty_pipe_ff[1];
  assign almost_full_flag_n_o = af_n_ff;
  assign almost_empty_flag_n_o = ae_n_ff;

  // ****************************************
  // output drive, echo clock and echo strobe
  // ****************************************
  logic drive_ff;
  logic echo_d1_ff;
  logic echo_d2_ff;
  logic echo_read_strobe_n_ff;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      drive_ff <= 1'b1;
    end else if (in_rst) begin
      drive_ff <= 1'b1;
    end else if (rclk_rise) begin
      drive_ff <= rsel;
    end
  end

  // two stages so the echo edge trails the data change
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      echo_d1_ff <= 1'b0;
      echo_d2_ff <= 1'b0;
      echo_read_strobe_n_ff <= 1'b1;
    end else begin
      echo_d1_ff <= pins.lvl[FRPS_PIN_RCLK];
      echo_d2_ff <= echo_d1_ff;
      if (in_rst) begin
        echo_read_strobe_n_ff <= 1'b1;
      end else if (rclk_rise) begin
        echo_read_strobe_n_ff <= ~rd_event;
      end
    end
  end

  wire [FRPS_WORD_W-1:0] lane_mask =
    (cfg_out_w_ff == FRPS_W20) ? {{FRPS_HALF_W{1'b0}}, {FRPS_HALF_W{1'b1}}} :
    (cfg_out_w_ff == FRPS_W10) ? {{(FRPS_WORD_W-FRPS_QTR_W){1'b0}}, {FRPS_QTR_W{1'b1}}} :
    {FRPS_WORD_W{1'b1}};
  wire bus_on = ~pins.lvl[FRPS_PIN_ODRV] & drive_ff;

  assign read_data_o = read_data_ff;
  assign read_data_oe_o = {FRPS_WORD_W{bus_on}} & lane_mask;
  assign echo_read_clock_o = echo_d2_ff;
  assign echo_read_strobe_n_o = echo_read_strobe_n_ff;

  // ****************************************
  // assertions
  // ****************************************
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  a_bus_drive_on: assert property (rclk_rise && rsel && !in_rst |=> drive_ff)
    else $error("read bus not driven after select low");
  a_bus_float_off: assert property (rclk_rise && !rsel && !in_rst |=> !drive_ff)
    else $error("read bus still driven after select high");
  a_reset_keeps_drive: assert property (in_rst |=> drive_ff)
    else $error("read bus released during reset");
  a_write_sel_block: assert property (!wsel && !in_rst |=> wptr_ff == $past(wptr_ff))
    else $error("write accepted with write select high");
  a_full_blocks_write: assert property (full_raw && !in_rst |=> wptr_ff == $past(wptr_ff))
    else $error("write accepted while full");
  a_full_flag_hold: assert property (!wclk_rise && !in_rst |=> $stable(full_pipe_ff))
    else $error("full flag moved without write clock");
  a_empty_no_pop: assert property (!cfg_first_word_fallthrough_ff && std_empty_raw && !in_rst
                                   |=> rptr_ff == $past(rptr_ff))
    else $error("read taken from empty fifo");
  a_fall_through: assert property (cfg_first_word_fallthrough_ff && rclk_rise && !ovalid_ff && !mem_empty
                                   && !empty_pipe_ff[1] && !in_rst |=> ovalid_ff)
    else $error("first word did not fall through");
  a_echo_delay: assert property (##3 echo_read_clock_o == $past(pins.lvl[FRPS_PIN_RCLK], 2))
    else $error("echo clock not a delayed read clock");
  a_strobe_read: assert property (rd_event |=> !echo_read_strobe_n_o)
    else $error("echo strobe missing for read");
  a_lane_narrow: assert property (cfg_out_w_ff == FRPS_W10
                                  |-> read_data_oe_o[FRPS_WORD_W-1:FRPS_QTR_W] == '0)
    else $error("unused read lines driven");

endmodule

//--- sim/frps_host.sv
`timescale 1ns/1ns
// ****************************************
// host side: pin clocks and write feeder
// ****************************************
module frps_host import frps_pkg::*; (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic wr_go_i,
  input wire logic [7:0] wr_num_i,
  input wire logic [FRPS_WORD_W-1:0] wr_base_i,
  output logic write_clk_o,
  output logic read_clk_o,
  output logic write_en_n_o,
  output logic [FRPS_WORD_W-1:0] write_data_o,
  output logic wr_busy_o
);
  logic [2:0] phase_ff;
  logic [7:0] left_ff;
  logic [FRPS_WORD_W-1:0] next_ff;
  assign write_clk_o = phase_ff[2];
  // quarter period away from the write clock
  assign read_clk_o = phase_ff[2] ^ phase_ff[1];
  assign wr_busy_o = (left_ff != 8'h00) || !write_en_n_o;
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      phase_ff <= 3'h0;
      left_ff <= 8'h00;
      next_ff <= '0;
      write_en_n_o <= 1'b1;
      write_data_o <= '0;
    end else begin
      phase_ff <= phase_ff + 3'h1;
      if (wr_go_i) begin
        left_ff <= wr_num_i;
        next_ff <= wr_base_i;
      end else if (phase_ff == 3'h7) begin
        // changes as the write clock falls; idle data toggles, never stale
        write_en_n_o <= (left_ff == 8'h00);
        write_data_o <= (left_ff == 8'h00) ? ~write_data_o : next_ff;
        if (left_ff != 8'h00) begin
          left_ff <= left_ff - 8'h01;
          next_ff <= next_ff + 40'h1;
        end
      end
    end
  end
endmodule

//--- sim/frps_tb_top.sv
`timescale 1ns/1ns
module frps_tb_top import frps_pkg::*; ;
  localparam logic [39:0] ALL = 40'hFF_FFFF_FFFF;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic master_reset_n = 1'b1;
  logic partial_reset_n = 1'b1;
  logic write_port_select_n = 1'b0;
  logic read_en_n = 1'b1;
  logic read_port_select_n = 1'b1;
  logic [2:0] width_cfg = 3'h0;
  logic [1:0] preset_sel = 2'h0;
  logic first_word_fallthrough = 1'b0;
  logic output_drive_n = 1'b0;
  logic retx_mode = 1'b0;
  logic mark = 1'b0;
  logic wr_go = 1'b0;
  logic [7:0] wr_num = 8'h00;
  logic [39:0] wr_base = 40'h0;
  logic write_clk, read_clk, write_en_n, wr_busy;
  logic [39:0] write_data, read_data, read_data_oe;
  logic full_ir, empty_or, af_n, ae_n, echo_clk, echo_stb_n;
  int failures = 0;
  int comparisons = 0;
  always #50 clk_sys = ~clk_sys;
  // ****************************************
  // device and host
  // ****************************************
  frps_top #(.DEPTH(16)) i_dut (.clk_sys_i(clk_sys), .sys_rst_i(sys_rst),
    .write_clk_i(write_clk), .read_clk_i(read_clk), .master_reset_n_i(master_reset_n),
    .partial_reset_n_i(partial_reset_n), .write_en_n_i(write_en_n),
    .write_port_select_n_i(write_port_select_n), .write_data_i(write_data),
    .read_en_n_i(read_en_n), .read_port_select_n_i(read_port_select_n),
    .output_drive_n_i(output_drive_n), .bus_match_enable_i(width_cfg[2]),
    .input_width_sel_i(width_cfg[1]), .output_width_sel_i(width_cfg[0]),
    .offset_preset_sel0_i(preset_sel[0]), .offset_preset_sel1_i(preset_sel[1]),
    .first_word_fallthrough_i(first_word_fallthrough), .retransmit_mode_i(retx_mode), .mark_i(mark),
    .read_data_o(read_data), .read_data_oe_o(read_data_oe), .full_flag_input_ready_o(full_ir),
    .empty_flag_output_ready_o(empty_or), .almost_full_flag_n_o(af_n),
    .almost_empty_flag_n_o(ae_n), .echo_read_clock_o(echo_clk),
    .echo_read_strobe_n_o(echo_stb_n));
  frps_host i_host (.clk_sys_i(clk_sys), .sys_rst_i(sys_rst), .wr_go_i(wr_go),
    .wr_num_i(wr_num), .wr_base_i(wr_base), .write_clk_o(write_clk), .read_clk_o(read_clk),
    .write_en_n_o(write_en_n), .write_data_o(write_data), .wr_busy_o(wr_busy));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic conclude;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk1(input logic got, input logic exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic chk40(input logic [39:0] got, input logic [39:0] exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wait_pin(input bit rd_side, input logic lvl);
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (((rd_side ? read_clk : write_clk) !== lvl) && n < 40);
    if (n >= 40) begin
      failures++;
      conclude();
    end
  endtask
  task automatic rise(input bit rd_side, input int k);
    repeat (k) begin
      wait_pin(rd_side, 1'b0);
      wait_pin(rd_side, 1'b1);
    end
  endtask
  task automatic wr(input int n, input logic [39:0] base);
    int k;
    k = 0;
    wr_num <= 8'(n);
    wr_base <= base;
    wr_go <= 1'b1;
    cyc(1);
    wr_go <= 1'b0;
    cyc(1);
    while (wr_busy !== 1'b0 && k < 2000) begin
      cyc(1);
      k++;
    end
    if (k >= 2000) begin
      failures++;
      conclude();
    end
    // flags trail the last write by a few pin clock rises
    rise(1'b0, 3);
    rise(1'b1, 4);
  endtask
  task automatic rd(input logic [39:0] exp, input logic [39:0] mask, input bit judge);
    wait_pin(1'b1, 1'b0);
    read_en_n <= 1'b0;
    read_port_select_n <= 1'b0;
    wait_pin(1'b1, 1'b1);
    cyc(5);
    if (judge) begin
      chk40(read_data & mask, exp, "read word");
      chk1(echo_stb_n, 1'b0, "echo strobe");
    end
    wait_pin(1'b1, 1'b0);
    read_en_n <= 1'b1;
    cyc(1);
  endtask
  task automatic mrst(input logic [2:0] wcfg, input logic [1:0] fsel, input logic ff);
    master_reset_n <= 1'b0;
    width_cfg <= wcfg;
    preset_sel <= fsel;
    first_word_fallthrough <= ff;
    cyc(8);
    master_reset_n <= 1'b1;
    cyc(8);
    rise(1'b1, 1);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_std_fill;
    mrst(3'b000, 2'h0, 1'b0);
    chk1(empty_or, 1'b0, "empty after reset");
    wr(7, 40'hA0_0000_0000);
    chk1(empty_or, 1'b1, "not empty, select high");
    chk1(ae_n, 1'b0, "at empty offset");
    wr(1, 40'hA0_0000_0007);
    chk1(ae_n, 1'b1, "above empty offset");
    chk1(af_n, 1'b1, "below full offset");
    wr(1, 40'hA0_0000_0008);
    chk1(af_n, 1'b0, "depth minus offset");
    chk1(full_ir, 1'b1, "not yet full");
    wr(7, 40'hA0_0000_0009);
    chk1(full_ir, 1'b0, "full at depth");
    wr(1, ALL);
    $display("done std fill");
  endtask
  task automatic t_std_read;
    wait_pin(1'b1, 1'b0);
    read_en_n <= 1'b0;
    rise(1'b1, 1);
    cyc(5);
    chk1(echo_stb_n, 1'b1, "deselected read");
    chk40(read_data_oe, 40'h0, "bus floats");
    for (int i = 0; i < 16; i++) begin
      rd(40'hA0_0000_0000 + 40'(i), ALL, 1'b1);
      chk40(read_data_oe, ALL, "bus driven");
    end
    rd(40'h0, ALL, 1'b0);
    chk1(echo_stb_n, 1'b1, "read when empty");
    chk40(read_data, 40'hA0_0000_000F, "data held");
    chk1(empty_or, 1'b0, "empty again");
    chk1(ae_n, 1'b0, "almost empty");
    read_port_select_n <= 1'b1;
    $display("done std read");
  endtask
  task automatic t_wsel_prst;
    write_port_select_n <= 1'b1;
    wr(2, 40'hB0_0000_0000);
    chk1(empty_or, 1'b0, "deselected writes");
    write_port_select_n <= 1'b0;
    wr(1, 40'hB0_0000_0002);
    partial_reset_n <= 1'b0;
    cyc(8);
    chk40(read_data_oe, ALL, "driven in reset");
    output_drive_n <= 1'b1;
    cyc(4);
    chk40(read_data_oe, 40'h0, "drive off in reset");
    output_drive_n <= 1'b0;
    cyc(4);
    partial_reset_n <= 1'b1;
    rise(1'b1, 2);
    cyc(5);
    chk40(read_data_oe, 40'h0, "floats after reset");
    chk1(empty_or, 1'b0, "reset empties");
    $display("done select and reset");
  endtask
  task automatic t_first_word_fallthrough;
    mrst(3'b000, 2'h0, 1'b1);
    chk1(full_ir, 1'b0, "room left");
    chk1(empty_or, 1'b1, "nothing valid");
    wr(2, 40'hC0_0000_0000);
    chk1(empty_or, 1'b0, "first word valid");
    chk40(read_data, 40'hC0_0000_0000, "fell through");
    chk40(read_data_oe, 40'h0, "floats deselected");
    wait_pin(1'b1, 1'b0);
    read_port_select_n <= 1'b0;
    rise(1'b1, 1);
    cyc(5);
    chk40(read_data_oe, ALL, "bus driven");
    chk40(read_data, 40'hC0_0000_0000, "first word kept");
    rd(40'hC0_0000_0001, ALL, 1'b1);
    chk1(empty_or, 1'b0, "last word valid");
    rd(40'h0, ALL, 1'b0);
    rise(1'b1, 3);
    chk1(empty_or, 1'b1, "true read");
    chk40(read_data, 40'hC0_0000_0001, "last word held");
    read_port_select_n <= 1'b1;
    wr(9, 40'hD0_0000_0000);
    chk1(af_n, 1'b1, "below full offset");
    wr(1, 40'hD0_0000_0009);
    chk1(af_n, 1'b0, "depth plus one minus offset");
    wr(6, 40'hD0_0000_000A);
    chk1(full_ir, 1'b0, "room for one");
    wr(1, 40'hD0_0000_0010);
    chk1(full_ir, 1'b1, "no room");
    $display("done fall-through");
  endtask
  task automatic t_width;
    logic [2:0] cfg [3] = '{3'b100, 3'b101, 3'b110};
    int wd [3] = '{20, 10, 40};
    logic [39:0] word;
    logic [39:0] mask;
    for (int c = 0; c < 3; c++) begin
      mrst(cfg[c], 2'h0, 1'b0);
      word = (c == 2) ? 40'h12_3451_2346 : 40'h12_3456_789A;
      wr((c == 2) ? 2 : 1, (c == 2) ? 40'h00_0001_2345 : word);
      mask = ~(ALL << wd[c]);
      for (int k = 0; k < 40 / wd[c]; k++) begin
        rd((word >> (40 - wd[c] * (k + 1))) & mask, mask, 1'b1);
      end
      chk40(read_data_oe, mask, "driven lanes");
      rise(1'b1, 3);
      chk1(empty_or, 1'b0, "port word count");
      read_port_select_n <= 1'b1;
    end
    mrst(3'b000, 2'h1, 1'b0);
    wr(9, 40'hE0_0000_0000);
    chk1(ae_n, 1'b0, "second preset");
    $display("done widths");
  endtask
  task automatic t_retx;
    mrst(3'b000, 2'h0, 1'b0);
    wr(4, 40'hF0_0000_0000);
    mark <= 1'b1;
    rise(1'b1, 2);
    mark <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd(40'hF0_0000_0000 + 40'(i), ALL, 1'b1);
    end
    // select stays low from the reads while the mark compare is on
    retx_mode <= 1'b1;
    wr(12, 40'hF0_0000_0004);
    chk1(full_ir, 1'b0, "full against mark");
    retx_mode <= 1'b0;
    rise(1'b0, 3);
    chk1(full_ir, 1'b1, "room against read pointer");
    read_port_select_n <= 1'b1;
    $display("done mark compare");
  endtask
  task automatic t_echo;
    rise(1'b1, 1);
    cyc(2);
    chk1(echo_clk, 1'b0, "echo lags");
    cyc(4);
    chk1(echo_clk, 1'b1, "echo follows");
    $display("done echo");
  endtask
  initial begin
    cyc(8);
    sys_rst <= 1'b0;
    t_std_fill();
    t_std_read();
    t_wsel_prst();
    t_first_word_fallthrough();
    t_width();
    t_retx();
    t_echo();
    conclude();
  end
endmodule
